// [hw/usb_dev_cfg_host.sv]
// Host controller: AXI4-Lite registers driving link commands.
// Assumes one AXI master and the device end on clk_sys.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "usb_dev_cfg_defines.svh"

module usb_dev_cfg_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   usb_dev_cfg_if.host_end lnk,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   usb_dev_cfg_pkg::host_state_t h_reg;
   usb_dev_cfg_pkg::host_state_t h_next;

   // ==========================================
   // Next state
   always_comb begin
      logic idle;
      idle = (h_reg.st == usb_dev_cfg_pkg::H_IDLE);
      h_next = h_reg;
      h_next.cmd_stb = 1'b0;
      h_next.rd_stb = 1'b0;
      h_next.wr_stb = 1'b0;

      // Write channels, taken in either order
      if (s_axi_awvalid && h_reg.awready) begin
         h_next.aw_hold = 1'b1;
         h_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && h_reg.wready) begin
         h_next.w_hold = 1'b1;
         h_next.w_data = s_axi_wdata;
      end
      if (h_reg.bvalid && s_axi_bready) begin
         h_next.bvalid = 1'b0;
      end
      if (h_reg.aw_hold && h_reg.w_hold && !h_reg.bvalid) begin
         h_next.aw_hold = 1'b0;
         h_next.w_hold = 1'b0;
         h_next.bvalid = 1'b1;
         h_next.bresp = `AXI_OKAY;
         unique case (h_reg.aw_addr)
            `HREG_IEN_WR: begin
               if (idle) begin
                  h_next.cmd_stb = 1'b1;
                  h_next.cmd_code = `CMD_IEN_WR;
                  h_next.out32 = {8'h00, h_reg.w_data[23:0]};
                  h_next.words_left = `WORDS_IEN;
                  h_next.st = usb_dev_cfg_pkg::H_WR;
               end
            end
            `HREG_DMA_WR: begin
               if (idle) begin
                  h_next.cmd_stb = 1'b1;
                  h_next.cmd_code = `CMD_DMA_WR;
                  h_next.out32 = h_reg.w_data;
                  h_next.words_left = `WORDS_DMA;
                  h_next.st = usb_dev_cfg_pkg::H_WR;
               end
            end
            `HREG_CTRL: begin
               if (idle && h_reg.w_data[`HCTRL_RD_IEN]) begin
                  h_next.cmd_stb = 1'b1;
                  h_next.cmd_code = `CMD_IEN_RD;
                  h_next.words_left = `WORDS_IEN;
                  h_next.st = usb_dev_cfg_pkg::H_RD;
               end else if (idle && h_reg.w_data[`HCTRL_RD_DMA]) begin
                  h_next.cmd_stb = 1'b1;
                  h_next.cmd_code = `CMD_DMA_RD;
                  h_next.words_left = `WORDS_DMA;
                  h_next.st = usb_dev_cfg_pkg::H_RD;
               end
            end
            `HREG_STATUS, `HREG_IEN_RD, `HREG_DMA_RD: begin
            end
            default: begin
               h_next.bresp = `AXI_SLVERR;
            end
         endcase
      end
      h_next.awready = !h_next.aw_hold && !h_next.bvalid;
      h_next.wready = !h_next.w_hold && !h_next.bvalid;

      // Read channel
      if (h_reg.rvalid && s_axi_rready) begin
         h_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && h_reg.arready) begin
         h_next.rvalid = 1'b1;
         h_next.rresp = `AXI_OKAY;
         unique case (s_axi_araddr)
            `HREG_STATUS: h_next.rdata = {31'h00000000, !idle};
            `HREG_IEN_RD: h_next.rdata = h_reg.ien_rd;
            `HREG_DMA_RD: h_next.rdata = {16'h0000, h_reg.dma_rd};
            `HREG_IEN_WR, `HREG_DMA_WR, `HREG_CTRL: h_next.rdata = 32'h00000000;
            default: begin
               h_next.rdata = 32'h00000000;
               h_next.rresp = `AXI_SLVERR;
            end
         endcase
      end
      h_next.arready = !h_next.rvalid;

      // Link: command, then words low first
      unique case (h_reg.st)
         usb_dev_cfg_pkg::H_IDLE: begin
         end
         usb_dev_cfg_pkg::H_WR: begin
            if (h_reg.wr_stb && h_reg.words_left == `WORDS_ONE) begin
               h_next.st = usb_dev_cfg_pkg::H_IDLE;
            end else begin
               h_next.wr_stb = 1'b1;
               h_next.wdata = h_reg.wr_stb ? h_reg.out32[31:16] : h_reg.out32[15:0];
               if (h_reg.wr_stb) begin
                  h_next.words_left = h_reg.words_left - `WORDS_ONE;
               end
            end
         end
         usb_dev_cfg_pkg::H_RD: begin
            h_next.rd_stb = 1'b1;
            h_next.st = usb_dev_cfg_pkg::H_WAIT;
         end
         usb_dev_cfg_pkg::H_WAIT: begin
            if (lnk.rd_valid) begin
               h_next.rd_acc = {lnk.rdata, h_reg.rd_acc[31:16]};
               if (h_reg.words_left == `WORDS_ONE) begin
                  h_next.st = usb_dev_cfg_pkg::H_IDLE;
                  if (h_reg.cmd_code == `CMD_IEN_RD) begin
                     h_next.ien_rd = {lnk.rdata, h_reg.rd_acc[31:16]};
                  end else begin
                     h_next.dma_rd = lnk.rdata;
                  end
               end else begin
                  h_next.words_left = h_reg.words_left - `WORDS_ONE;
                  h_next.st = usb_dev_cfg_pkg::H_RD;
               end
            end
         end
      endcase
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   // ==========================================
   // Outputs
   assign s_axi_awready = h_reg.awready;
   assign s_axi_wready = h_reg.wready;
   assign s_axi_bvalid = h_reg.bvalid;
   assign s_axi_bresp = h_reg.bresp;
   assign s_axi_arready = h_reg.arready;
   assign s_axi_rvalid = h_reg.rvalid;
   assign s_axi_rdata = h_reg.rdata;
   assign s_axi_rresp = h_reg.rresp;
   assign lnk.cmd_stb = h_reg.cmd_stb;
   assign lnk.cmd_code = h_reg.cmd_code;
   assign lnk.wr_stb = h_reg.wr_stb;
   assign lnk.wdata = h_reg.wdata;
   assign lnk.rd_stb = h_reg.rd_stb;

endmodule : usb_dev_cfg_host

// [include/usb_dev_cfg_defines.svh]
// Constants for the device bank and host controller.
// Assumes inclusion by bare name.
`ifndef USB_DEV_CFG_DEFINES_SVH
`define USB_DEV_CFG_DEFINES_SVH

// ==========================================
// Command codes
`define CMD_IEN_WR 8'hC2
`define CMD_IEN_RD 8'hC3
`define CMD_DMA_WR 8'hF0
`define CMD_DMA_RD 8'hF1

// ==========================================
// Interrupt enable layout
`define IEN_RST 24'h000000
`define IEN_WMASK 16'hFF7F
`define IEN_HI_MASK 8'hFF
`define EV_EOT 3

// ==========================================
// DMA setup layout
`define DMA_CFG_RST 16'h0000
`define DMA_CNT_RST 16'h0000
`define DMA_CNT_END 15
`define DMA_SHORT 14
`define DMA_LAST_W 8
`define DMA_EP_HI 7
`define DMA_EP_LO 4
`define DMA_RUN 3
`define DMA_BURST_HI 1
`define DMA_BURST_LO 0
`define DMA_STEP_BYTE 16'h0001
`define DMA_STEP_WORD 16'h0002

// ==========================================
// Host controller register map (byte addresses)
`define HREG_IEN_WR 6'h00
`define HREG_DMA_WR 6'h04
`define HREG_CTRL 6'h08
`define HREG_STATUS 6'h0C
`define HREG_IEN_RD 6'h10
`define HREG_DMA_RD 6'h14
`define HCTRL_RD_IEN 0
`define HCTRL_RD_DMA 1
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define WORDS_IEN 2'h2
`define WORDS_DMA 2'h1
`define WORDS_ONE 2'h1

`endif

// [include/usb_dev_cfg_pkg.sv]
// Types shared by device end and host controller.
// Assumes the defines header alongside.
package usb_dev_cfg_pkg;

   // ==========================================
   // Device command tracking
   typedef enum logic [2:0] {
      DC_IDLE = 3'h0,
      DC_IEN_WR0 = 3'h1,
      DC_IEN_WR1 = 3'h2,
      DC_IEN_RD0 = 3'h3,
      DC_IEN_RD1 = 3'h4,
      DC_DMA_WR = 3'h5,
      DC_DMA_RD = 3'h6
   } dev_cmd_t;

   typedef enum logic [1:0] {
      BURST_1 = 2'h0,
      BURST_4 = 2'h1,
      BURST_8 = 2'h2,
      BURST_16 = 2'h3
   } burst_len_t;

   typedef struct packed {
      dev_cmd_t cmd;
      logic [23:0] ien;
      logic count_end_gen;
      logic short_pkt_mode;
      logic last_access_width;
      logic [3:0] dma_target_ep;
      logic dma_run;
      burst_len_t burst_len_sel;
      logic [15:0] cnt;
      logic [23:0] ev_prev;
      logic [23:0] status;
      logic irq;
      logic xfer_end;
      logic [15:0] rdata;
      logic rd_valid;
   } dev_state_t;

   // ==========================================
   // Host controller sequencing
   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_WR = 2'h1,
      H_RD = 2'h2,
      H_WAIT = 2'h3
   } host_seq_t;

   typedef struct packed {
      host_seq_t st;
      logic awready;
      logic wready;
      logic aw_hold;
      logic [5:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic cmd_stb;
      logic [7:0] cmd_code;
      logic wr_stb;
      logic [15:0] wdata;
      logic rd_stb;
      logic [1:0] words_left;
      logic [31:0] out32;
      logic [31:0] rd_acc;
      logic [31:0] ien_rd;
      logic [15:0] dma_rd;
   } host_state_t;

endpackage : usb_dev_cfg_pkg

// [include/usb_dev_cfg_if.sv]
// Command link between host controller and device bank.
// Assumes both ends run on the same clk_sys.
`timescale 1ns/1ps
interface usb_dev_cfg_if;
   logic cmd_stb;
   logic [7:0] cmd_code;
   logic wr_stb;
   logic [15:0] wdata;
   logic rd_stb;
   logic [15:0] rdata;
   logic rd_valid;

   modport dev_end (input cmd_stb, input cmd_code, input wr_stb, input wdata, input rd_stb,
                    output rdata, output rd_valid);
   modport host_end (output cmd_stb, output cmd_code, output wr_stb, output wdata, output rd_stb,
                     input rdata, input rd_valid);
endinterface : usb_dev_cfg_if

// [hw/usb_dev_cfg_end.sv]
// Device end: interrupt enable and DMA setup registers.
// Assumes synchronous inputs on clk_sys and commands before words.
`timescale 1ns/1ps
`include "usb_dev_cfg_defines.svh"

// How it works
// - Disabled source never raises the interrupt output
// - Enabling mid-event does not catch that event
// - Enable gates status capture, not a mask
// - Bus reset keeps interrupt enables unchanged
// - C2/C3 move enables as two words
// - Software writes zero to bits 31-24
// - Bits 23-8 enable endpoint interrupts
// - Bit 6 enables short packet interrupt
// - Bits 5,4 enable pseudo and real SOF
// - Bits 3-0 enable EOT, suspend, resume, reset
// - F0/F1 move DMA setup as one word
// - Bus reset clears only the DMA run bit
// - Bit 15: end transfer when count hits zero
// - Bit 14: short OUT packet ends transfer
// - Software keeps short mode off for IN
// - Bit 8 reads last access width
// - Bits 7-4 pick the DMA endpoint
// - Bit 3 starts, stops, shows DMA run
// - Bits 1-0 select burst length
// - Run re-enable reloads the transfer counter
module usb_dev_cfg_end (
   input wire logic clk_sys,
   input wire logic rst_n,
   usb_dev_cfg_if.dev_end lnk,
   input wire logic [23:0] irq_event,
   input wire logic [23:0] irq_status_clr,
   input wire logic usb_bus_reset,
   input wire logic [15:0] dma_byte_count,
   input wire logic dma_beat,
   input wire logic dma_beat_word,
   input wire logic short_pkt_rx,
   output logic irq_out,
   output logic [23:0] irq_status_latch,
   output logic dma_run,
   output logic [3:0] dma_target_ep,
   output logic [1:0] burst_len_sel,
   output logic xfer_end,
   output logic [15:0] dma_count_left
);

   usb_dev_cfg_pkg::dev_state_t state_reg;
   usb_dev_cfg_pkg::dev_state_t state_next;

   // ==========================================
   // Helpers
   function automatic logic [15:0] pack_dma_setup(input usb_dev_cfg_pkg::dev_state_t s);
      logic [15:0] w;
      w = `DMA_CFG_RST;
      w[`DMA_CNT_END] = s.count_end_gen;
      w[`DMA_SHORT] = s.short_pkt_mode;
      w[`DMA_LAST_W] = s.last_access_width;
      w[`DMA_EP_HI:`DMA_EP_LO] = s.dma_target_ep;
      w[`DMA_RUN] = s.dma_run;
      w[`DMA_BURST_HI:`DMA_BURST_LO] = s.burst_len_sel;
      return w;
   endfunction : pack_dma_setup

   function automatic usb_dev_cfg_pkg::dev_cmd_t decode_cmd(input logic [7:0] code);
      usb_dev_cfg_pkg::dev_cmd_t c;
      c = usb_dev_cfg_pkg::DC_IDLE;
      if (code == `CMD_IEN_WR) begin
         c = usb_dev_cfg_pkg::DC_IEN_WR0;
      end else if (code == `CMD_IEN_RD) begin
         c = usb_dev_cfg_pkg::DC_IEN_RD0;
      end else if (code == `CMD_DMA_WR) begin
         c = usb_dev_cfg_pkg::DC_DMA_WR;
      end else if (code == `CMD_DMA_RD) begin
         c = usb_dev_cfg_pkg::DC_DMA_RD;
      end
      return c;
   endfunction : decode_cmd

   // ==========================================
   // Next state
   always_comb begin
      logic [23:0] rise;
      logic [15:0] step;
      logic eot;
      rise = '0;
      step = `DMA_STEP_BYTE;
      eot = 1'b0;
      state_next = state_reg;
      state_next.rd_valid = 1'b0;
      state_next.xfer_end = 1'b0;

      // Command and word handling
      unique case (state_reg.cmd)
         usb_dev_cfg_pkg::DC_IDLE: begin
         end
         usb_dev_cfg_pkg::DC_IEN_WR0: begin
            if (lnk.wr_stb) begin
               state_next.ien[15:0] = lnk.wdata & `IEN_WMASK;
               state_next.cmd = usb_dev_cfg_pkg::DC_IEN_WR1;
            end
         end
         usb_dev_cfg_pkg::DC_IEN_WR1: begin
            if (lnk.wr_stb) begin
               state_next.ien[23:16] = lnk.wdata[7:0] & `IEN_HI_MASK;
               state_next.cmd = usb_dev_cfg_pkg::DC_IDLE;
            end
         end
         usb_dev_cfg_pkg::DC_IEN_RD0: begin
            if (lnk.rd_stb) begin
               state_next.rdata = state_reg.ien[15:0];
               state_next.rd_valid = 1'b1;
               state_next.cmd = usb_dev_cfg_pkg::DC_IEN_RD1;
            end
         end
         usb_dev_cfg_pkg::DC_IEN_RD1: begin
            if (lnk.rd_stb) begin
               state_next.rdata = {8'h00, state_reg.ien[23:16]};
               state_next.rd_valid = 1'b1;
               state_next.cmd = usb_dev_cfg_pkg::DC_IDLE;
            end
         end
         usb_dev_cfg_pkg::DC_DMA_WR: begin
            if (lnk.wr_stb) begin
               state_next.count_end_gen = lnk.wdata[`DMA_CNT_END];
               state_next.short_pkt_mode = lnk.wdata[`DMA_SHORT];
               state_next.dma_target_ep = lnk.wdata[`DMA_EP_HI:`DMA_EP_LO];
               state_next.dma_run = lnk.wdata[`DMA_RUN];
               state_next.burst_len_sel =
                  usb_dev_cfg_pkg::burst_len_t'(lnk.wdata[`DMA_BURST_HI:`DMA_BURST_LO]);
               state_next.cmd = usb_dev_cfg_pkg::DC_IDLE;
            end
         end
         usb_dev_cfg_pkg::DC_DMA_RD: begin
            if (lnk.rd_stb) begin
               state_next.rdata = pack_dma_setup(state_reg);
               state_next.rd_valid = 1'b1;
               state_next.cmd = usb_dev_cfg_pkg::DC_IDLE;
            end
         end
         default: begin
            state_next.cmd = usb_dev_cfg_pkg::DC_IDLE;
         end
      endcase
      if (lnk.cmd_stb) begin
         state_next.cmd = decode_cmd(lnk.cmd_code);
      end

      // Transfer count and end of transfer
      if (state_reg.dma_run && dma_beat) begin
         step = dma_beat_word ? `DMA_STEP_WORD : `DMA_STEP_BYTE;
         state_next.last_access_width = dma_beat_word;
         state_next.cnt = (state_reg.cnt > step) ? state_reg.cnt - step : `DMA_CNT_RST;
         if (state_reg.count_end_gen && state_reg.cnt <= step) begin
            eot = 1'b1;
         end
      end
      if (state_reg.dma_run && state_reg.short_pkt_mode && short_pkt_rx) begin
         eot = 1'b1;
      end
      // Ending a transfer also stops the run
      if (eot) begin
         state_next.dma_run = 1'b0;
         state_next.xfer_end = 1'b1;
      end
      // Bus reset stops DMA and keeps all else
      if (usb_bus_reset) begin
         state_next.dma_run = 1'b0;
      end
      if (state_next.dma_run && !state_reg.dma_run) begin
         state_next.cnt = dma_byte_count;
      end

      // Status capture gated at event onset
      state_next.ev_prev = irq_event;
      // Onset only: a late enable misses a running event
      rise = irq_event & ~state_reg.ev_prev;
      rise[`EV_EOT] = rise[`EV_EOT] | eot;
      // Set wins over a same-cycle clear
      state_next.status = (state_reg.status & ~irq_status_clr) | (rise & state_reg.ien);
      state_next.irq = |state_next.status;
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{cmd: usb_dev_cfg_pkg::DC_IDLE, ien: `IEN_RST, cnt: `DMA_CNT_RST,
                        burst_len_sel: usb_dev_cfg_pkg::BURST_1, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Outputs
   assign lnk.rdata = state_reg.rdata;
   assign lnk.rd_valid = state_reg.rd_valid;
   assign irq_out = state_reg.irq;
   assign irq_status_latch = state_reg.status;
   assign dma_run = state_reg.dma_run;
   assign dma_target_ep = state_reg.dma_target_ep;
   assign burst_len_sel = state_reg.burst_len_sel;
   assign xfer_end = state_reg.xfer_end;
   assign dma_count_left = state_reg.cnt;

endmodule : usb_dev_cfg_end

// [tb/usb_dev_cfg_monitor.sv]
// Checker for the host-to-device command link.
// Assumes it sits beside the link interface, on clk_sys.
`timescale 1ns/1ps
`include "usb_dev_cfg_defines.svh"
module usb_dev_cfg_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_stb,
   input wire logic [7:0] cmd_code,
   input wire logic wr_stb,
   input wire logic [15:0] wdata,
   input wire logic rd_stb,
   input wire logic [15:0] rdata,
   input wire logic rd_valid
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Command sequences
   sequence s_ien_wr;
      cmd_stb && cmd_code == `CMD_IEN_WR;
   endsequence
   sequence s_dma_wr;
      cmd_stb && cmd_code == `CMD_DMA_WR;
   endsequence
   sequence s_ien_rd;
      cmd_stb && cmd_code == `CMD_IEN_RD ##1 rd_stb ##1 rd_valid;
   endsequence
   sequence s_dma_rd;
      cmd_stb && cmd_code == `CMD_DMA_RD ##1 rd_stb ##1 rd_valid;
   endsequence

   // ==========================================
   // Properties
   property p_rd_answer;
      rd_stb |=> rd_valid;
   endproperty
   property p_rd_cause;
      rd_valid |-> $past(rd_stb);
   endproperty
   property p_rd_single;
      rd_stb |=> !rd_stb;
   endproperty
   property p_rdata_hold;
      !rd_valid |-> $stable(rdata);
   endproperty
   property p_ien_wr_words;
      s_ien_wr |=> wr_stb ##1 wr_stb ##1 !wr_stb;
   endproperty
   property p_ien_wr_hi;
      s_ien_wr ##2 wr_stb |-> wdata[15:8] == 8'h00;
   endproperty
   property p_dma_wr_word;
      s_dma_wr |=> wr_stb ##1 !wr_stb;
   endproperty
   property p_ien_rd_rsv;
      s_ien_rd |-> !rdata[7] ##2 rd_stb ##1 (rd_valid && rdata[15:8] == 8'h00);
   endproperty
   property p_dma_rd_rsv;
      s_dma_rd |-> rdata[13:9] == 5'h00 && !rdata[2];
   endproperty

   a_rd_answer: assert property (p_rd_answer)
      else $error("read word not answered");
   a_rd_cause: assert property (p_rd_cause)
      else $error("read answer without request");
   a_rd_single: assert property (p_rd_single)
      else $error("read requests back to back");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved idle");
   a_ien_wr_words: assert property (p_ien_wr_words)
      else $error("enable write not two words");
   a_ien_wr_hi: assert property (p_ien_wr_hi)
      else $error("enable high byte not zero");
   a_dma_wr_word: assert property (p_dma_wr_word)
      else $error("dma setup write not one word");
   a_ien_rd_rsv: assert property (p_ien_rd_rsv)
      else $error("enable reserved bits set");
   a_dma_rd_rsv: assert property (p_dma_rd_rsv)
      else $error("dma reserved bits set");
endmodule : usb_dev_cfg_monitor

// [tb/testbench.sv]
// Bench: host controller and device end on one link.
// Assumes all design and include files compiled first.
`timescale 1ns/1ps
`include "usb_dev_cfg_defines.svh"
module testbench;
   logic clk_sys = 1'h0;
   logic rst_n;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, burst_len_sel;
   logic [23:0] irq_event, irq_status_clr, irq_status_latch;
   logic usb_bus_reset, dma_beat, dma_beat_word, short_pkt_rx, irq_out, dma_run, xfer_end;
   logic [15:0] dma_byte_count, dma_count_left;
   logic [3:0] dma_target_ep;
   int error_cnt = 0;
   int comparisons = 0;

   always #12.5 clk_sys = ~clk_sys;

   usb_dev_cfg_if lnk ();
   usb_dev_cfg_host u_usb_dev_cfg_host (.clk_sys, .rst_n, .lnk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   usb_dev_cfg_end u_usb_dev_cfg_end (.clk_sys, .rst_n, .lnk, .irq_event, .irq_status_clr,
      .usb_bus_reset, .dma_byte_count, .dma_beat, .dma_beat_word, .short_pkt_rx, .irq_out,
      .irq_status_latch, .dma_run, .dma_target_ep, .burst_len_sel, .xfer_end, .dma_count_left);
   usb_dev_cfg_monitor u_usb_dev_cfg_monitor (.clk_sys, .rst_n, .cmd_stb(lnk.cmd_stb),
      .cmd_code(lnk.cmd_code), .wr_stb(lnk.wr_stb), .wdata(lnk.wdata), .rd_stb(lnk.rd_stb),
      .rdata(lnk.rdata), .rd_valid(lnk.rd_valid));

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge clk_sys);
   endtask : axw

   task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge clk_sys);
   endtask : axr

   // Write, then wait for link idle
   task automatic put(input logic [5:0] a, input logic [31:0] d);
      logic [1:0] r;
      logic [31:0] s;
      axw(a, d, r);
      do axr(`HREG_STATUS, s, r); while (s[0] !== 1'h0);
   endtask : put

   task automatic rdreg(input logic ien, output logic [31:0] d);
      logic [1:0] r;
      put(`HREG_CTRL, ien ? 32'h00000001 : 32'h00000002);
      axr(ien ? `HREG_IEN_RD : `HREG_DMA_RD, d, r);
   endtask : rdreg

   task automatic clr();
      irq_status_clr <= 24'hFFFFFF;
      @(posedge clk_sys);
      irq_status_clr <= 24'h000000;
      @(posedge clk_sys);
   endtask : clr

   // One beat or short packet; count end pulses
   task automatic ev(input logic b, input logic w, input logic s, output int n);
      dma_beat <= b;
      dma_beat_word <= w;
      short_pkt_rx <= s;
      @(posedge clk_sys);
      dma_beat <= 1'h0;
      short_pkt_rx <= 1'h0;
      n = 0;
      repeat (4) begin
         @(posedge clk_sys);
         if (xfer_end === 1'h1) n++;
      end
   endtask : ev

   // ==========================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] d;
      chk(irq_out, 32'h0);
      rdreg(1'h1, d);
      chk(d, 32'h0);
      rdreg(1'h0, d);
      chk(d, 32'h0);
   endtask : t_reset

   task automatic t_gate();
      logic [23:0] pat [3] = '{24'hAAAA55, 24'h55552A, 24'h000000};
      foreach (pat[i]) begin
         put(`HREG_IEN_WR, {8'h00, pat[i]});
         clr();
         irq_event <= 24'hFFFFFF;
         @(posedge clk_sys);
         irq_event <= 24'h000000;
         repeat (2) @(posedge clk_sys);
         chk(irq_status_latch, pat[i]);
         chk(irq_out, |pat[i]);
      end
   endtask : t_gate

   task automatic t_midevent();
      put(`HREG_IEN_WR, 32'h0);
      clr();
      irq_event <= 24'h000001;
      put(`HREG_IEN_WR, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk(irq_status_latch, 32'h0);
      chk(irq_out, 32'h0);
      irq_event <= 24'h000000;
      @(posedge clk_sys);
      irq_event <= 24'h000001;
      @(posedge clk_sys);
      irq_event <= 24'h000000;
      repeat (2) @(posedge clk_sys);
      chk(irq_status_latch, 32'h1);
   endtask : t_midevent

   task automatic t_hold();
      logic [31:0] d;
      put(`HREG_IEN_WR, 32'hFFFFFFFF);
      rdreg(1'h1, d);
      chk(d, 32'h00FFFF7F);
      put(`HREG_DMA_WR, 32'h0000FFFD);
      chk({dma_run, dma_target_ep, burst_len_sel}, 32'h7D);
      rdreg(1'h0, d);
      chk(d, 32'h0000C0F9);
      usb_bus_reset <= 1'h1;
      @(posedge clk_sys);
      usb_bus_reset <= 1'h0;
      repeat (2) @(posedge clk_sys);
      chk({dma_run, dma_target_ep, burst_len_sel}, 32'h3D);
      rdreg(1'h0, d);
      chk(d, 32'h0000C0F1);
      rdreg(1'h1, d);
      chk(d, 32'h00FFFF7F);
   endtask : t_hold

   task automatic t_modes();
      int n;
      for (int k = 0; k < 4; k++) begin
         put(`HREG_DMA_WR, 32'h8 | k | (k << 4));
         chk({dma_target_ep, burst_len_sel}, k * 5);
      end
      put(`HREG_DMA_WR, 32'h0);
      chk(dma_run, 32'h0);
      for (int m = 0; m < 2; m++) begin
         put(`HREG_DMA_WR, 32'h8 | (m << 14));
         ev(1'h0, 1'h0, 1'h1, n);
         chk(n, m);
         chk(dma_run, 1 - m);
      end
   endtask : t_modes

   task automatic t_count();
      logic [31:0] d;
      int n;
      put(`HREG_IEN_WR, 32'h8);
      clr();
      dma_byte_count <= 16'h0003;
      put(`HREG_DMA_WR, 32'h8008);
      chk(dma_count_left, 32'h3);
      ev(1'h1, 1'h0, 1'h0, n);
      chk(n, 0);
      ev(1'h1, 1'h1, 1'h0, n);
      chk(n, 1);
      chk({dma_run, irq_status_latch}, 32'h8);
      rdreg(1'h0, d);
      chk(d, 32'h8100);
      dma_byte_count <= 16'h0001;
      put(`HREG_DMA_WR, 32'h8008);
      chk(dma_count_left, 32'h1);
      ev(1'h1, 1'h0, 1'h0, n);
      chk(n, 1);
      rdreg(1'h0, d);
      chk(d, 32'h8000);
   endtask : t_count

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      axw(6'h20, 32'hFFFFFFFF, r);
      chk(r, `AXI_SLVERR);
      axr(6'h3C, d, r);
      chk(r, `AXI_SLVERR);
      chk(d, 32'h0);
   endtask : t_unmapped

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // ==========================================
   // Main sequence and watchdog
   initial begin
      rst_n = 1'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {irq_event, irq_status_clr, dma_byte_count} = '0;
      {usb_bus_reset, dma_beat, dma_beat_word, short_pkt_rx} = '0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      t_reset();
      t_gate();
      t_midevent();
      t_hold();
      t_modes();
      t_count();
      t_unmapped();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
endmodule : testbench
